// file: rtl/hu_pkg.sv
// Package: constants and carrier types of the HCI serial port
// ==========================================================
// What this block does
// [RL1] Four wires: receive, transmit, and an RTS/CTS flow-control pair.
// [RL2] Baud generator programmable from 115200 bit/s to 1.5 Mbit/s.
// [RL3] Supports 115200, 921600, 1500000 and any intermediate rate in range.
// [RL4] Rate may change during operation on a host vendor command.
// [RL5] Combined baud error of both ends must stay within five percent.
// [RL6] Receive and transmit FIFOs hold 1040 bytes each.
// [RL7] Traffic follows H4 framing: indicator byte before each packet.
// [RL8] After reset the port runs at 115.2 kbaud.
// [RL9] A wake output toward the host asserts when the host must wake.
// [RL10] Wake output stays inactive until a vendor command enables it.
// [RL11] Auxiliary port instance is identical but with 256-byte FIFOs.
// [RL12] Each auxiliary port signal is routable to any general pin.
// [RL13] Host without flow control holds our CTS input low.
// [RL14] Character: start bit, eight data bits LSB first, no parity, one stop.
// [RL15] Drop RTS near receive full; no new character while CTS deasserted.
package hu_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned BAUD_MIN = 115200;
  localparam int unsigned BAUD_MAX = 1500000;
  localparam int unsigned BAUD_DEFAULT = 115200;
  // Divider is clock cycles per bit, held in 16 bits
  localparam int unsigned DIV_W = 16;
  localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / BAUD_MIN);
  localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / BAUD_MAX);
  localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam int unsigned FIFO_DEPTH_HCI = 1040;
  localparam int unsigned FIFO_DEPTH_AUX = 256;
  // RTS drops with this many free receive entries left
  localparam int unsigned RTS_MARGIN = 16;
  localparam int unsigned DATA_BITS = 8;

  typedef struct packed {
    logic rxd;
    logic cts_n;
  } hu_line_in_s;

  typedef struct packed {
    logic txd;
    logic rts_n;
  } hu_line_out_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } hu_byte_s;
endpackage : hu_pkg

// file: rtl/hu_fifo.sv
// Byte FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module hu_fifo #(
  parameter int unsigned DEPTH = 1040
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned LW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [LW-1:0] FULL = LW'(DEPTH);

  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [LW-1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign level = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : hu_fifo
`default_nettype wire

// file: rtl/hu_uart.sv
// HCI serial port: baud generator, framer, deframer, FIFOs, flow control, host wake
`timescale 1ns/10ps
`default_nettype none
module hu_uart #(
  parameter int unsigned FIFO_DEPTH = hu_pkg::FIFO_DEPTH_HCI
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial line
  input wire hu_pkg::hu_line_in_s line_in,
  output hu_pkg::hu_line_out_s line_out,
  // Host wake
  output logic host_wake,
  // Rate control from the command processor
  input wire logic rate_set,
  input wire logic [15:0] rate_div,
  output logic rate_err,
  // Wake control from the command processor
  input wire logic wake_enable_set,
  input wire logic wake_enable_clr,
  input wire logic wake_request,
  // Outgoing bytes from the controller
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Received bytes to the controller
  output hu_pkg::hu_byte_s rx_out,
  input wire logic rx_ready,
  // Status
  output logic rx_overrun,
  output logic frame_err
);
  import hu_pkg::*;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } hu_tx_e;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } hu_rx_e;

  localparam int unsigned LW = $clog2(FIFO_DEPTH + 1);
  localparam logic [LW-1:0] RTS_LEVEL = LW'(FIFO_DEPTH - RTS_MARGIN);

  function automatic logic div_ok(input logic [15:0] d);
    div_ok = (d >= DIV_MIN) && (d <= DIV_MAX);
  endfunction : div_ok

  // ==========================================================
  // Baud rate
  // ==========================================================
  logic [15:0] div_q;
  logic [15:0] div_pend_q;
  logic pend_q;
  logic tx_idle;
  logic rx_idle;

  // New rate takes effect between characters so no frame is torn
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      div_q <= DIV_RESET; // RL8
      div_pend_q <= DIV_RESET;
      pend_q <= 1'b0;
      rate_err <= 1'b0;
    end
    else
    begin
      if (rate_set)
      begin
        rate_err <= !div_ok(rate_div); // RL2
        if (div_ok(rate_div)) // RL3
        begin
          div_pend_q <= rate_div;
          pend_q <= 1'b1; // RL4
        end
      end
      else if (pend_q && tx_idle && rx_idle)
      begin
        div_q <= div_pend_q; // RL5
        pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Transmit path
  // ==========================================================
  logic txf_valid;
  logic [7:0] txf_data;
  logic txf_ready;

  hu_fifo #(.DEPTH(FIFO_DEPTH)) u_tx_fifo ( // RL6 RL11 RL7
    .clock(clock),
    .rst(rst),
    .in_valid(tx_valid),
    .in_data(tx_data),
    .in_ready(tx_ready),
    .out_valid(txf_valid),
    .out_data(txf_data),
    .out_ready(txf_ready),
    .level()
  );

  hu_tx_e tx_st_q;
  logic [15:0] tx_cnt_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic tx_tick;
  logic txd_q;
  logic rts_n_q;

  // One flop per wire, so the pin mux can route each on its own
  assign line_out = '{txd: txd_q, rts_n: rts_n_q}; // RL1 RL12
  assign tx_tick = (tx_cnt_q == div_q - 16'h0001);
  assign tx_idle = (tx_st_q == TX_IDLE);
  // CTS low means go; held low by hosts without flow control
  assign txf_ready = tx_idle && !line_in.cts_n && !pend_q; // RL15 RL13

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '0;
      txd_q <= 1'b1;
    end
    else
    begin
      tx_cnt_q <= (tx_idle || tx_tick) ? '0 : tx_cnt_q + 16'h0001;
      unique case (tx_st_q)
        TX_IDLE:
        begin
          txd_q <= 1'b1;
          if (txf_valid && txf_ready)
          begin
            tx_sh_q <= txf_data;
            txd_q <= 1'b0; // RL14
            tx_st_q <= TX_START;
          end
        end
        TX_START:
        begin
          if (tx_tick)
          begin
            txd_q <= tx_sh_q[0]; // RL14
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_bit_q <= '0;
            tx_st_q <= TX_DATA;
          end
        end
        TX_DATA:
        begin
          if (tx_tick)
          begin
            if (tx_bit_q == 3'(DATA_BITS - 1))
            begin
              txd_q <= 1'b1;
              tx_st_q <= TX_STOP;
            end
            else
            begin
              txd_q <= tx_sh_q[0];
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
        end
        TX_STOP:
        begin
          if (tx_tick)
          begin
            tx_st_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Receive path
  // ==========================================================
  hu_rx_e rx_st_q;
  logic [15:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_push;
  logic rxf_in_ready;
  logic rx_tick;
  logic rx_half;
  logic [LW-1:0] rx_level;
  logic rxf_valid;
  logic [7:0] rxf_data;
  logic rxf_pop;

  assign rx_tick = (rx_cnt_q == div_q - 16'h0001);
  assign rx_half = (rx_cnt_q == {1'b0, div_q[15:1]});
  assign rx_idle = (rx_st_q == RX_IDLE);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_push <= 1'b0;
      rx_overrun <= 1'b0;
      frame_err <= 1'b0;
    end
    else
    begin
      rx_push <= 1'b0;
      rx_overrun <= 1'b0;
      frame_err <= 1'b0;
      rx_cnt_q <= (rx_idle || rx_tick) ? '0 : rx_cnt_q + 16'h0001;
      unique case (rx_st_q)
        RX_IDLE:
        begin
          if (!line_in.rxd)
          begin
            rx_st_q <= RX_START;
          end
        end
        RX_START:
        begin
          // Glitch shorter than half a bit is not a start
          if (rx_half)
          begin
            rx_st_q <= line_in.rxd ? RX_IDLE : RX_DATA;
            rx_bit_q <= '0;
          end
        end
        RX_DATA:
        begin
          if (rx_half)
          begin
            rx_sh_q <= {line_in.rxd, rx_sh_q[7:1]}; // RL14
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'(DATA_BITS - 1))
            begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (rx_half)
          begin
            rx_st_q <= RX_IDLE;
            frame_err <= !line_in.rxd;
            rx_push <= line_in.rxd && rxf_in_ready;
            rx_overrun <= line_in.rxd && !rxf_in_ready;
          end
        end
      endcase
    end
  end

  hu_fifo #(.DEPTH(FIFO_DEPTH)) u_rx_fifo ( // RL6 RL11
    .clock(clock),
    .rst(rst),
    .in_valid(rx_push),
    .in_data(rx_sh_q),
    .in_ready(rxf_in_ready),
    .out_valid(rxf_valid),
    .out_data(rxf_data),
    .out_ready(rxf_pop),
    .level(rx_level)
  );

  // ==========================================================
  // Two-entry output skid buffer, registered outputs
  // ==========================================================
  hu_byte_s skid_q;
  assign rxf_pop = rxf_valid && (!rx_out.valid || rx_ready || !skid_q.valid);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_out <= '0;
      skid_q <= '0;
    end
    else
    begin
      if (!rx_out.valid || rx_ready)
      begin
        if (skid_q.valid)
        begin
          rx_out <= skid_q;
          skid_q <= rxf_pop ? {1'b1, rxf_data} : '0;
        end
        else
        begin
          rx_out <= rxf_pop ? {1'b1, rxf_data} : '0;
        end
      end
      else if (rxf_pop)
      begin
        skid_q <= {1'b1, rxf_data};
      end
    end
  end

  // ==========================================================
  // Flow control and host wake
  // ==========================================================
  logic wake_en_q;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rts_n_q <= 1'b0;
    end
    else
    begin
      rts_n_q <= (rx_level >= RTS_LEVEL); // RL15
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wake_en_q <= 1'b0;
      host_wake <= 1'b0;
    end
    else
    begin
      if (wake_enable_set)
      begin
        wake_en_q <= 1'b1; // RL10
      end
      else if (wake_enable_clr)
      begin
        wake_en_q <= 1'b0;
      end
      host_wake <= wake_en_q && (wake_request || txf_valid); // RL9
    end
  end
endmodule : hu_uart
`default_nettype wire

// file: sim/hu_uart_asserts.sv
// Concurrent checks on the HCI serial port ports
`timescale 1ns/10ps
`default_nettype none
module hu_uart_asserts
  import hu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched ports
  input wire hu_pkg::hu_line_out_s line_out,
  input wire logic host_wake,
  input wire logic rate_set,
  input wire logic [15:0] rate_div,
  input wire logic rate_err,
  input wire logic wake_enable_set,
  input wire logic wake_enable_clr,
  input wire logic wake_request,
  input wire hu_pkg::hu_byte_s rx_out,
  input wire logic rx_ready,
  input wire logic frame_err
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Longest legal low run: start plus eight zero bits at the slowest rate
  localparam logic [15:0] LOW_MAX = 16'(9 * int'(DIV_MAX) + 2);
  logic en_q;
  logic [15:0] low_q;
  always_ff @(posedge clock or posedge rst)
    if (rst)
      en_q <= 1'b0;
    else if (wake_enable_set)
      en_q <= 1'b1;
    else if (wake_enable_clr)
      en_q <= 1'b0;
  always_ff @(posedge clock or posedge rst)
    if (rst)
      low_q <= 16'h0000;
    else
      low_q <= line_out.txd ? 16'h0000 : low_q + 16'h0001;
  property p_rate_ok;
    rate_set && rate_div >= DIV_MIN && rate_div <= DIV_MAX |=> !rate_err;
  endproperty
  a_rate_ok: assert property (p_rate_ok) else $error("good divider flagged");
  property p_rate_bad;
    rate_set && (rate_div < DIV_MIN || rate_div > DIV_MAX) |=> rate_err;
  endproperty
  a_rate_bad: assert property (p_rate_bad) else $error("bad divider not flagged");
  property p_wake_off;
    !en_q && !$past(en_q) |-> !host_wake;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake while disabled");
  property p_wake_on;
    (en_q && wake_request) [*3] |-> host_wake;
  endproperty
  a_wake_on: assert property (p_wake_on) else $error("wake not raised");
  property p_rx_hold;
    rx_out.valid && !rx_ready |=> rx_out.valid && $stable(rx_out.data);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("stalled byte changed");
  property p_rts_free;
    !rx_out.valid [*3] |-> !line_out.rts_n;
  endproperty
  a_rts_free: assert property (p_rts_free) else $error("rts high while empty");
  property p_frame_pulse;
    frame_err |=> !frame_err;
  endproperty
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame error held");
  property p_low_run;
    low_q <= LOW_MAX;
  endproperty
  a_low_run: assert property (p_low_run) else $error("txd low too long");
endmodule : hu_uart_asserts
bind hu_uart hu_uart_asserts u_chk (.clock(clock), .rst(rst), .line_out(line_out),
  .host_wake(host_wake), .rate_set(rate_set), .rate_div(rate_div), .rate_err(rate_err),
  .wake_enable_set(wake_enable_set), .wake_enable_clr(wake_enable_clr),
  .wake_request(wake_request), .rx_out(rx_out), .rx_ready(rx_ready), .frame_err(frame_err));
`default_nettype wire

// file: sim/hu_host_model.sv
// Host-side serial model: sends characters and decodes the device's
`timescale 1ns/10ps
`default_nettype none
module hu_host_model (
  // Clock
  input wire logic clock,
  // Line
  input wire logic txd,
  output logic rxd,
  // Bit period in clock cycles, same as the device so no rate error
  input wire logic [15:0] div,
  // Decoded byte
  output logic got_valid,
  output logic [7:0] got_data,
  output logic got_bad
);
  logic [7:0] b;
  initial
  begin
    rxd = 1'b1;
    got_valid = 1'b0;
    got_data = 8'h00;
    got_bad = 1'b0;
  end
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clock);
      #1 rxd = f[i];
      repeat (div - 1) @(posedge clock);
    end
    @(posedge clock);
    #1 rxd = 1'b1;
  endtask : send
  // Mid-bit sampling, same as a host receiver
  always
  begin
    @(negedge txd);
    repeat (div / 2) @(posedge clock);
    if (txd === 1'b0)
    begin
      for (int i = 0; i < 8; i++)
      begin
        repeat (div) @(posedge clock);
        b[i] = txd;
      end
      repeat (div) @(posedge clock);
      #1 got_data = b;
      got_bad = (txd !== 1'b1);
      got_valid = 1'b1;
      @(posedge clock);
      #1 got_valid = 1'b0;
    end
  end
endmodule : hu_host_model
`default_nettype wire

// file: sim/hci_uart_with_host_wake_test.sv
// Self-checking bench of the HCI serial port
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module hci_uart_with_host_wake_test;
  import hu_pkg::*;
  // Small depth so fills stay short; RTS threshold is D-16
  localparam int unsigned D = 20;
  logic clock, rst, cts_n, hrxd, host_wake, rate_set, rate_err, wake_request;
  logic wake_enable_set, wake_enable_clr, tx_valid, tx_ready, rx_ready;
  logic rx_overrun, frame_err, got_valid, got_bad;
  logic [15:0] rate_div, hdiv;
  logic [7:0] tx_data, got_data, e;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  hu_line_in_s line_in;
  hu_line_out_s line_out;
  hu_byte_s rx_out;
  int miscompares, compares, cycles, n, ferrs, ovrs;
  assign line_in = '{rxd: hrxd, cts_n: cts_n};
  hu_uart #(.FIFO_DEPTH(D)) uut (.clock(clock), .rst(rst), .line_in(line_in),
    .line_out(line_out), .host_wake(host_wake), .rate_set(rate_set), .rate_div(rate_div),
    .rate_err(rate_err), .wake_enable_set(wake_enable_set), .wake_enable_clr(wake_enable_clr),
    .wake_request(wake_request), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_out(rx_out), .rx_ready(rx_ready), .rx_overrun(rx_overrun), .frame_err(frame_err));
  hu_host_model host (.clock(clock), .txd(line_out.txd), .rxd(hrxd), .div(hdiv),
    .got_valid(got_valid), .got_data(got_data), .got_bad(got_bad));
  always #5 clock = ~clock;
  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      miscompares++;
      test_done();
    end
  end
  // Result watcher: oldest note against each result
  always @(posedge clock)
  begin
    if (frame_err === 1'b1)
      ferrs++;
    if (rx_overrun === 1'b1)
      ovrs++;
    if (got_valid === 1'b1)
    begin
      `CHK("tx queued", 1'b1, txq.size() > 0)
      e = txq.pop_front();
      `CHK("txd byte", e, got_data)
      `CHK("txd stop", 1'b0, got_bad)
    end
    if (rx_out.valid === 1'b1 && rx_ready === 1'b1)
    begin
      `CHK("rx queued", 1'b1, rxq.size() > 0)
      e = rxq.pop_front();
      `CHK("rx byte", e, rx_out.data)
    end
  end
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask : tick
  task automatic put(input logic [7:0] b);
    tx_valid = 1'b1;
    tx_data = b;
    txq.push_back(b);
    do @(posedge clock); while (tx_ready !== 1'b1);
    #1;
  endtask : put
  task automatic rcv(input logic [7:0] b);
    rxq.push_back(b);
    host.send(b, 1'b1);
  endtask : rcv
  task automatic rate(input logic [15:0] d, input logic err);
    rate_div = d;
    rate_set = 1'b1;
    tick(1);
    `CHK("rate err", err, rate_err)
    rate_set = 1'b0;
    if (!err)
      hdiv = d;
    // One idle cycle so a back-to-back call cannot merge two strobes
    tick(1);
  endtask : rate
  task automatic drain(input string s);
    while (txq.size() > 0 || rxq.size() > 0)
      tick(1);
    tick(4);
    $display("test %s done", s);
  endtask : drain
  initial
  begin
    clock = 0; rst = 1; cts_n = 0; rate_set = 0; rate_div = 16'h0000;
    wake_request = 0; wake_enable_set = 0; wake_enable_clr = 0; tx_valid = 0;
    tx_data = 8'h00; rx_ready = 1; hdiv = DIV_RESET;
    n = $urandom(48);
    repeat (10) @(posedge clock);
    `CHK("reset outs", 5'h10, {line_out, host_wake, rx_out.valid, rate_err})
    #1 rst = 0;
    tick(2);
    put(8'h04);
    tx_valid = 1'b0;
    rcv(8'h01);
    drain("default rate");
    wake_request = 1'b1;
    tick(4);
    `CHK("wake idle", 1'b0, host_wake)
    wake_enable_set = 1'b1;
    tick(1);
    wake_enable_set = 1'b0;
    tick(4);
    `CHK("wake on", 1'b1, host_wake)
    wake_enable_clr = 1'b1;
    tick(1);
    wake_enable_clr = 1'b0;
    wake_request = 1'b0;
    tick(4);
    `CHK("wake off", 1'b0, host_wake)
    $display("test wake done");
    rate(16'h0041, 1'b1);
    rate(16'h0365, 1'b1);
    rate(16'h0000, 1'b1);
    rate(16'h0364, 1'b0);
    rate(16'(66 + $urandom % 400), 1'b0);
    put(8'($urandom));
    tx_valid = 1'b0;
    rcv(8'($urandom));
    drain("intermediate rate");
    rate(16'h0042, 1'b0);
    fork
      begin
        put(8'h01);
        repeat (5) put(8'($urandom));
        tx_valid = 1'b0;
      end
      repeat (6) rcv(8'($urandom));
    join
    drain("traffic");
    ferrs = 0;
    host.send(8'h5A, 1'b0);
    tick(hdiv * 2);
    `CHK("frame drop", 1, ferrs)
    drain("bad stop");
    cts_n = 1'b1;
    tx_valid = 1'b1;
    tx_data = 8'($urandom);
    n = 0;
    repeat (D + 8)
    begin
      @(posedge clock);
      if (tx_ready === 1'b1)
      begin
        txq.push_back(tx_data);
        n++;
        #1 tx_data = 8'($urandom);
      end
    end
    #1 tx_valid = 1'b0;
    `CHK("tx refused", 1'b0, tx_ready)
    `CHK("tx depth", 1'b1, n >= D && n <= D + 3)
    `CHK("cts hold", 1'b1, line_out.txd)
    `CHK("wake masked", 1'b0, host_wake)
    cts_n = 1'b0;
    drain("cts stall");
    rx_ready = 1'b0;
    repeat (D - 18) rcv(8'($urandom));
    tick(5);
    `CHK("rts low", 1'b0, line_out.rts_n)
    // Output register and skid entry hold two bytes outside the FIFO
    repeat (4) rcv(8'($urandom));
    tick(5);
    `CHK("rts high", 1'b1, line_out.rts_n)
    repeat (D - 4) rcv(8'($urandom));
    ovrs = 0;
    host.send(8'hA5, 1'b1);
    tick(5);
    `CHK("rx overrun", 1, ovrs)
    rx_ready = 1'b1;
    drain("rts fill");
    `CHK("rts back", 1'b0, line_out.rts_n)
    test_done();
  end
endmodule : hci_uart_with_host_wake_test
`default_nettype wire
